// *** rtl/sltc_consts.vh ***
`ifndef SLTC_CONSTS_VH
`define SLTC_CONSTS_VH
// register indexes; byte address is four times the index
`define SLTC_IDX_CKS 12'h573
`define SLTC_IDX_ILAS 12'h574
`define SLTC_IDX_STAT 12'h590
`define SLTC_IDX_USER 12'h591
// field positions
`define SLTC_CKS_MODE 7:6
`define SLTC_INJ_PT 5:4
`define SLTC_PAT 3:0
`define SLTC_ILAS_DLY 7:4
`define SLTC_LL_TEST 2:0
// reset values
`define SLTC_RST_CKS 8'h00
`define SLTC_RST_ILAS 8'h00
`define SLTC_RST_USER 16'h0000
// pattern codes
`define SLTC_P_NORM 4'h0
`define SLTC_P_CHK 4'h1
`define SLTC_P_TOG 4'h2
`define SLTC_P_PN31 4'h3
`define SLTC_P_PN23 4'h4
`define SLTC_P_PN15 4'h5
`define SLTC_P_PN9 4'h6
`define SLTC_P_PN7 4'h7
`define SLTC_P_RAMP 4'h8
`define SLTC_P_UREP 4'hE
`define SLTC_P_USGL 4'hF
// checksum modes and injection points
`define SLTC_CK_OCT 2'h0
`define SLTC_CK_FLD 2'h1
`define SLTC_INJ_SMP 2'h0
`define SLTC_INJ_10B 2'h1
`define SLTC_INJ_SCR 2'h2
// link test codes and characters
`define SLTC_LL_NORM 3'h0
`define SLTC_LL_D215 3'h1
`define SLTC_K285 8'hBC
`define SLTC_K280 8'h1C
`define SLTC_D215 8'hB5
// timing: multiframes of alignment sequence, generator seed
`define SLTC_ILAS_MF 3'h4
`define SLTC_PN_SEED 31'h7FFFFFFF
`endif

// *** rtl/sltc_ctrl.v ***
`timescale 1ns/1ps
`include "sltc_consts.vh"
// Notes on behaviour
// R01: checksum mode 10 sends zero checksum; 11 unused, also sends zero.
// R02: checksum mode 00 sums all configuration octets.
// R03: checksum mode 01 sums each configuration field, LSB aligned.
// R04: injection point 0 puts the pattern on the sample input.
// R05: injection point 1 drives pattern as 10-bit words after the encoder.
// R06: injection point 2 drives pattern as bytes at scrambler input.
// R07: pattern codes pick normal, checkerboard, toggle, ramp, user patterns.
// R08: code 0011 gives PN sequence x^31 + x^28 + 1.
// R09: code 0100 gives PN sequence x^23 + x^18 + 1.
// R10: code 0101 gives PN sequence x^15 + x^14 + 1.
// R11: code 0110 gives x^9 + x^5 + 1, code 0111 gives x^7 + x^6 + 1.
// R12: alignment sequence starts at LMFC boundary n+1 after sync release.
// R13: while receiver requests sync, send /K28.5/ characters. With link test 001 the code sends /D21.5/ instead.
// R14: link test 000 carries normal traffic.
// R15: link test 001 sends unbroken /D21.5/ characters.
// R16: nonzero test code replaces converter data until normal code restored.
// R17: generators restart from a seed when their code is newly selected.
module sltc_ctrl #(
  parameter N_OCT = 14,
  parameter N_FLD = 20
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire [15:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // link side
  input wire sync_request_input_n,
  input wire lmfc_tick,
  input wire [8*N_OCT-1:0] cfg_octets,
  input wire [8*N_FLD-1:0] cfg_fields,
  // data path
  input wire [15:0] samp_in,
  input wire [7:0] byte_in,
  output reg [15:0] samp_out_q,
  output reg [7:0] tx_byte_q,
  output reg tx_k_q,
  output reg [9:0] raw10_q,
  output reg raw10_sel_q,
  output reg [7:0] checksum_q
);

  localparam ST_CGS = 2'b00;
  localparam ST_WAIT = 2'b01;
  localparam ST_ILAS = 2'b10;
  localparam ST_DATA = 2'b11;

  reg [7:0] cks_ctrl_q;
  reg [7:0] ilas_ctrl_q;
  reg [15:0] user_q;
  reg [2:0] sync_sh_q;
  reg sync_req_q;
  reg [1:0] st_q;
  reg [3:0] lmfc_cnt_q;
  reg [2:0] mf_cnt_q;
  reg [3:0] pat_prev_q;
  reg [30:0] pn_q;
  reg [15:0] pat_q;
  reg phase_q;
  reg user_done_q;
  reg [7:0] cks_d;
  reg [31:0] rd_d;
  reg bad_d;
  integer i;

  wire [3:0] pat = cks_ctrl_q[`SLTC_PAT];
  wire [1:0] inj = cks_ctrl_q[`SLTC_INJ_PT];
  wire [2:0] ll = ilas_ctrl_q[`SLTC_LL_TEST];
  wire [3:0] ilas_dly = ilas_ctrl_q[`SLTC_ILAS_DLY];
  wire acc = psel & penable & ~pready;
  wire wr_ok = psel & penable & pready & pwrite & ~pslverr;
  wire [11:0] idx = paddr[13:2];
  wire pat_new = pat != pat_prev_q;

  // alignment marker: first at the start boundary, then once per multiframe
  wire ilas_go = !sync_req_q && lmfc_tick && st_q == ST_WAIT &&
    lmfc_cnt_q == ilas_dly;
  wire mf_mark = !sync_req_q && lmfc_tick && st_q == ST_ILAS &&
    mf_cnt_q != `SLTC_ILAS_MF - 3'h1;

  // word-aligned register index match, used for reads and writes
  function hit;
    input [11:0] a;
    input [11:0] r;
    begin
      hit = a == r;
    end
  endfunction

  // advance the generator 16 bits; taps chosen per code
  function [30:0] pn_adv;
    input [30:0] s;
    input [3:0] c;
    integer k;
    reg fb;
    reg [30:0] t;
    begin
      t = s;
      for (k = 0; k < 16; k = k + 1) begin
        case (c)
          `SLTC_P_PN31: fb = t[30] ^ t[27]; // R08
          `SLTC_P_PN23: fb = t[22] ^ t[17]; // R09
          `SLTC_P_PN15: fb = t[14] ^ t[13]; // R10
          `SLTC_P_PN9: fb = t[8] ^ t[4]; // R11
          default: fb = t[6] ^ t[5]; // R11
        endcase
        t = {t[29:0], fb};
      end
      pn_adv = t;
    end
  endfunction

  // read mux and unmapped-address check
  always @* begin
    rd_d = 32'h00000000;
    bad_d = 1'b0;
    if (hit(idx, `SLTC_IDX_CKS)) begin
      rd_d[7:0] = cks_ctrl_q;
    end else if (hit(idx, `SLTC_IDX_ILAS)) begin
      rd_d[7:0] = {ilas_ctrl_q[7:4], 1'b0, ilas_ctrl_q[2:0]};
    end else if (hit(idx, `SLTC_IDX_STAT)) begin
      rd_d[7:0] = {sync_req_q, 1'b0, lmfc_cnt_q, st_q};
    end else if (hit(idx, `SLTC_IDX_USER)) begin
      rd_d[15:0] = user_q;
    end else begin
      bad_d = 1'b1;
    end
  end

  // one wait state: answer registered in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= acc;
      pslverr <= acc & bad_d;
      if (acc & ~pwrite) begin
        prdata <= rd_d;
      end
    end
  end

  // register writes take effect on the completing edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cks_ctrl_q <= `SLTC_RST_CKS;
      ilas_ctrl_q <= `SLTC_RST_ILAS;
      user_q <= `SLTC_RST_USER;
    end else if (wr_ok) begin
      if (hit(idx, `SLTC_IDX_CKS)) begin
        cks_ctrl_q <= pwdata[7:0];
      end else if (hit(idx, `SLTC_IDX_ILAS)) begin
        ilas_ctrl_q <= {pwdata[7:4], 1'b0, pwdata[2:0]}; // bit 3 reserved
      end else if (hit(idx, `SLTC_IDX_USER)) begin
        user_q <= pwdata[15:0];
      end
    end
  end

  // pin synchroniser; a change counts once stages two and three agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_sh_q <= 3'b111;
      sync_req_q <= 1'b1;
    end else begin
      sync_sh_q <= {sync_sh_q[1:0], ~sync_request_input_n};
      if (sync_sh_q[2] == sync_sh_q[1]) begin
        sync_req_q <= sync_sh_q[2];
      end
    end
  end

  // link sequence: sync, delay, alignment, data
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_CGS;
      lmfc_cnt_q <= 4'h0;
      mf_cnt_q <= 3'h0;
    end else if (sync_req_q) begin
      st_q <= ST_CGS; // R13
      lmfc_cnt_q <= 4'h0;
      mf_cnt_q <= 3'h0;
    end else begin
      case (st_q)
        ST_CGS: begin
          st_q <= ST_WAIT;
        end
        ST_WAIT: begin
          if (lmfc_tick) begin
            if (lmfc_cnt_q == ilas_dly) begin
              st_q <= ST_ILAS; // R12
            end
            lmfc_cnt_q <= lmfc_cnt_q + 4'h1;
          end
        end
        ST_ILAS: begin
          if (lmfc_tick) begin
            mf_cnt_q <= mf_cnt_q + 3'h1;
            if (mf_cnt_q == `SLTC_ILAS_MF - 3'h1) begin
              st_q <= ST_DATA;
            end
          end
        end
        default: begin
          st_q <= ST_DATA;
        end
      endcase
    end
  end

  // pattern generators; reseeded whenever the code changes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pat_prev_q <= `SLTC_P_NORM;
      pn_q <= `SLTC_PN_SEED;
      pat_q <= 16'h0000;
      phase_q <= 1'b0;
      user_done_q <= 1'b0;
    end else begin
      pat_prev_q <= pat;
      if (pat_new) begin
        pn_q <= `SLTC_PN_SEED; // R17
        pat_q <= 16'h0000;
        phase_q <= 1'b0;
        user_done_q <= 1'b0;
      end else begin
        phase_q <= ~phase_q;
        pn_q <= pn_adv(pn_q, pat);
        case (pat) // R07
          `SLTC_P_CHK: pat_q <= phase_q ? 16'hAAAA : 16'h5555;
          `SLTC_P_TOG: pat_q <= phase_q ? 16'hFFFF : 16'h0000;
          `SLTC_P_PN31, `SLTC_P_PN23, `SLTC_P_PN15,
          `SLTC_P_PN9, `SLTC_P_PN7: pat_q <= pn_q[15:0];
          `SLTC_P_RAMP: pat_q <= pat_q + 16'h0001;
          `SLTC_P_UREP: pat_q <= user_q;
          `SLTC_P_USGL: begin
            // single shot: user word once, then zeros
            pat_q <= user_done_q ? 16'h0000 : user_q;
            user_done_q <= 1'b1;
          end
          default: pat_q <= 16'h0000;
        endcase
      end
    end
  end

  // checksum; field mode expects each field zero-padded to a byte
  always @* begin
    cks_d = 8'h00;
    case (cks_ctrl_q[`SLTC_CKS_MODE])
      `SLTC_CK_OCT: begin
        for (i = 0; i < N_OCT; i = i + 1) begin
          cks_d = cks_d + cfg_octets[8*i +: 8]; // R02
        end
      end
      `SLTC_CK_FLD: begin
        for (i = 0; i < N_FLD; i = i + 1) begin
          cks_d = cks_d + cfg_fields[8*i +: 8]; // R03
        end
      end
      default: cks_d = 8'h00; // R01
    endcase
  end

  // output stage; test codes hold until software writes normal back
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_out_q <= 16'h0000;
      tx_byte_q <= `SLTC_K285;
      tx_k_q <= 1'b1;
      raw10_q <= 10'h000;
      raw10_sel_q <= 1'b0;
      checksum_q <= 8'h00;
    end else begin
      checksum_q <= cks_d;
      raw10_q <= pat_q[9:0];
      raw10_sel_q <= pat != `SLTC_P_NORM && inj == `SLTC_INJ_10B; // R05
      if (pat != `SLTC_P_NORM && inj == `SLTC_INJ_SMP) begin
        samp_out_q <= pat_q; // R04 R16
      end else begin
        samp_out_q <= samp_in;
      end
      if (ll == `SLTC_LL_D215) begin
        tx_byte_q <= `SLTC_D215; // R15 R16
        tx_k_q <= 1'b0;
      end else if (ilas_go || mf_mark) begin
        tx_byte_q <= `SLTC_K280; // R12
        tx_k_q <= 1'b1;
      end else if (st_q == ST_CGS || st_q == ST_WAIT) begin
        tx_byte_q <= `SLTC_K285; // R13
        tx_k_q <= 1'b1;
      end else if (pat != `SLTC_P_NORM && inj == `SLTC_INJ_SCR) begin
        tx_byte_q <= pat_q[7:0]; // R06 R16
        tx_k_q <= 1'b0;
      end else begin
        tx_byte_q <= byte_in; // R14
        tx_k_q <= 1'b0;
      end
    end
  end

endmodule

// *** tb/sltc_ctrl_properties.sv ***
`timescale 1ns/1ps
module sltc_ctrl_properties (
  // apb side
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // link side
  input wire sync_request_input_n,
  input wire lmfc_tick,
  input wire [7:0] tx_byte_q,
  input wire tx_k_q
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // exactly one wait state, then a single-cycle answer
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  a_ready_needs_req: assert property (pready |-> psel && penable)
    else $error("ready outside an access");
  a_ready_idle_bus: assert property (!psel |=> !pready)
    else $error("ready after idle bus");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_read_zero: assert property (pready && pslverr && !pwrite |->
    prdata == 32'h0) else $error("refused read not zero");
  // three sync stages, request flop, state flop and output flop before the comma shows
  a_sync_sends_k: assert property ((!sync_request_input_n) [*7] |->
    (tx_k_q && tx_byte_q == 8'hBC) || (!tx_k_q && tx_byte_q == 8'hB5))
    else $error("no comma during sync request");
  a_align_on_tick: assert property (tx_k_q && tx_byte_q == 8'h1C |->
    $past(lmfc_tick)) else $error("alignment start off boundary");
endmodule
bind sltc_ctrl sltc_ctrl_properties u_sltc_ctrl_properties (.pclk, .presetn,
  .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
  .sync_request_input_n, .lmfc_tick, .tx_byte_q, .tx_k_q);

// *** tb/sltc_ctrl_tb_top.sv ***
`timescale 1ns/1ps
`include "sltc_consts.vh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module sltc_ctrl_tb_top;
  logic pclk, presetn, psel, penable, pwrite, sync_req, err;
  logic [15:0] paddr;
  logic [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire pready, pslverr, sync_request_input_n, lmfc_tick, tx_k_q, raw10_sel_q;
  wire [111:0] cfg_octets = {14{8'h11}};
  wire [159:0] cfg_fields = {20{8'h05}};
  wire [15:0] samp_in = 16'h1234;
  wire [7:0] byte_in = 8'h3C;
  wire [15:0] samp_out_q;
  wire [7:0] tx_byte_q, checksum_q;
  wire [9:0] raw10_q;
  int n_errors = 0;
  int compares = 0;
  sltc_ctrl u_sltc_ctrl (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .sync_request_input_n, .lmfc_tick,
    .cfg_octets, .cfg_fields, .samp_in, .byte_in, .samp_out_q, .tx_byte_q,
    .tx_k_q, .raw10_q, .raw10_sel_q, .checksum_q);
  sltc_rx_model u_sltc_rx_model (.pclk, .presetn, .sync_req,
    .sync_request_input_n, .lmfc_tick);
  // one apb transfer; the leading edge keeps drives apart
  task automatic xfer(input logic w, input logic [11:0] i,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait as long as the slave needs; only the watchdog ends a hang
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic setp(input logic [7:0] c);
    xfer(1'b1, `SLTC_IDX_CKS, {24'h0, c});
    repeat (3) @(posedge pclk);
  endtask
  task automatic t_regs;
    xfer(1'b0, `SLTC_IDX_CKS, 32'h0);
    `CHK(rd, 32'h0)
    xfer(1'b0, `SLTC_IDX_ILAS, 32'h0);
    `CHK(rd, 32'h0)
    xfer(1'b1, `SLTC_IDX_ILAS, 32'hFF);
    xfer(1'b0, `SLTC_IDX_ILAS, 32'h0);
    `CHK(rd, 32'hF7)
    xfer(1'b0, 12'h100, 32'h0);
    `CHK({err, rd}, 33'h100000000)
    xfer(1'b1, `SLTC_IDX_ILAS, 32'h0);
  endtask
  // count boundaries between sync release and the first non-comma
  task automatic t_ilas(input logic [3:0] n);
    int t;
    t = 0;
    sync_req <= 1'b1;
    xfer(1'b1, `SLTC_IDX_ILAS, {24'h0, n, 4'h0});
    repeat (10) @(posedge pclk);
    `CHK({tx_k_q, tx_byte_q}, 9'h1BC)
    while (lmfc_tick !== 1'b1) @(posedge pclk);
    sync_req <= 1'b0;
    for (int k = 0; k < 200 && tx_byte_q === 8'hBC; k++) begin
      @(posedge pclk);
      t += lmfc_tick;
    end
    `CHK(t, n + 1)
    `CHK({tx_k_q, tx_byte_q}, 9'h11C)
    repeat (40) @(posedge pclk);
    `CHK({tx_k_q, tx_byte_q}, 9'h03C)
  endtask
  // shift recurrence with taps l and m; newest word sits in [15:0]
  function automatic logic pn_ok(input logic [47:0] v, input int l,
    input int m);
    pn_ok = 1'b1;
    for (int i = 0; i < 16; i++) begin
      if (v[i] !== (v[i + l] ^ v[i + m])) pn_ok = 1'b0;
    end
  endfunction
  task automatic t_d215;
    xfer(1'b1, `SLTC_IDX_ILAS, 32'h1);
    repeat (3) @(posedge pclk);
    `CHK({tx_k_q, tx_byte_q}, 9'h0B5)
    sync_req <= 1'b1;
    repeat (8) @(posedge pclk);
    `CHK({tx_k_q, tx_byte_q}, 9'h0B5)
    xfer(1'b1, `SLTC_IDX_ILAS, 32'h0);
    repeat (3) @(posedge pclk);
    `CHK({tx_k_q, tx_byte_q}, 9'h1BC)
    sync_req <= 1'b0;
    repeat (200) @(posedge pclk);
  endtask
  // each PN generator and the ramp: replaces data, restarts alike, follows its polynomial or ramp step
  task automatic t_pat;
    logic [15:0] a;
    logic [15:0] lo;
    logic [47:0] v;
    for (int c = 3; c < 9; c++) begin
      setp(8'(c));
      repeat (2) @(posedge pclk);
      a = samp_out_q;
      setp(8'h00);
      `CHK(samp_out_q, samp_in)
      setp(8'(c));
      repeat (2) @(posedge pclk);
      `CHK(samp_out_q, a)
      @(posedge pclk);
      `CHK(samp_out_q != a, 1'b1)
      for (int k = 0; k < 3; k++) begin
        @(posedge pclk);
        v = {v[31:0], samp_out_q};
      end
      case (c)
        3: `CHK(pn_ok(v, 31, 28), 1'b1)
        4: `CHK(pn_ok(v, 23, 18), 1'b1)
        5: `CHK(pn_ok(v, 15, 14), 1'b1)
        6: `CHK(pn_ok(v, 9, 5), 1'b1)
        7: `CHK(pn_ok(v, 7, 6), 1'b1)
        default: `CHK(v[15:0], v[31:16] + 16'h0001)
      endcase
    end
    // reseed word and first generated word pass before the check
    for (int c = 1; c < 3; c++) begin
      setp(8'(c));
      repeat (2) @(posedge pclk);
      a = samp_out_q;
      lo = (c == 1) ? 16'h5555 : 16'h0000;
      `CHK(a == lo || a == ~lo, 1'b1)
      @(posedge pclk);
      `CHK(samp_out_q ^ a, 16'hFFFF)
    end
    xfer(1'b1, `SLTC_IDX_USER, 32'hC3A5);
    setp(8'h0E);
    repeat (2) @(posedge pclk);
    `CHK(samp_out_q, 16'hC3A5)
    setp(8'h0F);
    @(posedge pclk);
    `CHK(samp_out_q, 16'hC3A5)
    repeat (2) @(posedge pclk);
    `CHK(samp_out_q, 16'h0000)
  endtask
  task automatic t_inj;
    setp(8'h11);
    repeat (2) @(posedge pclk);
    `CHK({raw10_sel_q, raw10_q == 10'h155 || raw10_q == 10'h2AA}, 2'h3)
    setp(8'h21);
    `CHK({raw10_sel_q, tx_byte_q == 8'h55 || tx_byte_q == 8'hAA}, 2'h1)
    `CHK(samp_out_q, samp_in)
    setp(8'h80);
    `CHK(checksum_q, 8'h00)
    setp(8'h00);
    `CHK(checksum_q, 8'hEE)
    setp(8'h40);
    `CHK(checksum_q, 8'h64)
  endtask
  task automatic wrap_up;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // watchdog well beyond the thousand or so cycles the run needs
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    wrap_up;
  end
  initial begin
    {presetn, psel, penable, pwrite, sync_req} = 5'h01;
    paddr = 16'h0000;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_ilas(4'h0);
    t_ilas(4'h5);
    t_ilas(4'hF);
    t_d215;
    t_pat;
    t_inj;
    wrap_up;
  end
endmodule

// *** tb/sltc_rx_model.sv ***
`timescale 1ns/1ps
module sltc_rx_model #(
  parameter LMFC_P = 8
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // bench control
  input wire sync_req,
  // link pins
  output reg sync_request_input_n,
  output reg lmfc_tick
);
  reg [7:0] cnt_q;
  // receiver keeps sync requested until the bench lets go
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_request_input_n <= 1'b0;
      cnt_q <= 8'h00;
      lmfc_tick <= 1'b0;
    end else begin
      sync_request_input_n <= !sync_req;
      lmfc_tick <= (cnt_q == LMFC_P - 1);
      cnt_q <= (cnt_q == LMFC_P - 1) ? 8'h00 : cnt_q + 8'h01;
    end
  end
endmodule
